// [hw/strb_pkg.sv]
// constants, codes and register map of the ssp target response builder
// Function
// RULE_01 - any reception-complete message sends the machine back to its idle start state
// RULE_02 - ask next write window only below total, at window end, all acks in
// RULE_03 - new length is total minus old offset, then offset becomes bytes received
// RULE_04 - response frame carries frame type code 07h
// RULE_05 - retry, retransmit, changing pointer bits and transfer tag, data offset are zero
// RULE_06 - destination hash from argument, source hash from own address, tag from argument
// RULE_07 - transport response: response data present, status zero, lengths zero and four
// RULE_08 - transport argument maps one to one onto the response data code
// RULE_09 - transport response fill count follows the response data length
// RULE_10 - application response: status copied, sense present or no data, sense length copied
// RULE_11 - application response: response length zero, sense bytes appended, fill from sense length
// RULE_12 - finished frame goes to the send stage, a cancel passes a cancel indication
// RULE_13 - each accepted write data frame adds its data byte count to bytes received
// RULE_14 - cancel during write reception sends complete with transfer terminated and tag
// RULE_15 - fill count zero to three so the unit ends on a four byte boundary
package strb_pkg;
	// frame header and information unit layout, header bytes by frame position, unit fields by offset from IU_BASE
	localparam logic [7:0]  FRAME_TYPE_RESPONSE = 8'h07;
	localparam logic [31:0] TPORT_RESP_LEN      = 32'h00000004;
	localparam logic [15:0] HB_FRAME_TYPE       = 16'h0000;
	localparam logic [15:0] HB_DEST             = 16'h0001;
	localparam logic [15:0] HB_SRC              = 16'h0005;
	localparam logic [15:0] HB_FLAGS            = 16'h000A;
	localparam logic [15:0] HB_FILL             = 16'h000B;
	localparam logic [15:0] HB_TAG              = 16'h0010;
	localparam logic [15:0] IU_BASE             = 16'h0018;
	localparam logic [15:0] IU_DATAPRES         = 16'h000A;
	localparam logic [15:0] IU_STATUS           = 16'h000B;
	localparam logic [15:0] IU_SENSE_LEN        = 16'h0010;
	localparam logic [15:0] IU_RESP_LEN         = 16'h0014;
	localparam logic [15:0] PAYLOAD_START       = 16'h0030;
	localparam logic [15:0] RESP_CODE_POS       = 16'h0003;
	localparam logic [1:0]  DATAPRES_NONE       = 2'h0;
	localparam logic [1:0]  DATAPRES_RESP       = 2'h1;
	localparam logic [1:0]  DATAPRES_SENSE      = 2'h2;
	// response data codes
	localparam logic [7:0]  RC_COMPLETE         = 8'h00;
	localparam logic [7:0]  RC_INVALID_FRAME    = 8'h02;
	localparam logic [7:0]  RC_NOT_SUPPORTED    = 8'h04;
	localparam logic [7:0]  RC_FAILED           = 8'h05;
	localparam logic [7:0]  RC_SUCCEEDED        = 8'h08;
	localparam logic [7:0]  RC_BAD_LUN          = 8'h09;
	localparam logic [7:0]  RC_OVERLAP_TAG      = 8'h0A;
	// transport response arguments
	typedef enum logic [2:0] {
		STRB_TA_INVALID_FRAME = 3'b000,
		STRB_TA_COMPLETE      = 3'b001,
		STRB_TA_SUCCEEDED     = 3'b010,
		STRB_TA_NOT_SUPPORTED = 3'b011,
		STRB_TA_FAILED        = 3'b100,
		STRB_TA_BAD_LUN       = 3'b101,
		STRB_TA_OVERLAP_TAG   = 3'b110
	} strb_targ_e;
	// reception complete codes
	localparam logic [2:0]  RX_DATA_RECEIVED    = 3'h0;
	localparam logic [2:0]  RX_TERMINATED       = 3'h1;
	localparam logic [2:0]  RX_TOO_MUCH         = 3'h2;
	localparam logic [2:0]  RX_IU_TOO_SHORT     = 3'h3;
	// register byte addresses and interrupt bits
	localparam logic [5:0]  REG_OWN_HASH        = 6'h00;
	localparam logic [5:0]  REG_STATE           = 6'h04;
	localparam logic [5:0]  REG_RCVD            = 6'h08;
	localparam logic [5:0]  REG_IRQ_STATUS      = 6'h0C;
	localparam logic [5:0]  REG_IRQ_MASK        = 6'h10;
	localparam int          IRQ_RX_DONE         = 0;
	localparam int          IRQ_XFER_RDY        = 1;
	localparam int          IRQ_FRAME_SENT      = 2;
	localparam int          IRQ_CANCEL          = 3;
	localparam int          IRQ_BITS            = 4;
	localparam logic [23:0] OWN_HASH_RESET      = 24'h000000;
endpackage

// [hw/strb_top.sv]
// ssp target response builder: write data window tracking and response frame streaming
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module strb_top #(
	parameter int SLW = 8
) (
	input  wire logic             ref_clk_in,
	input  wire logic             rst_in,
	input  wire logic [5:0]       avs_address_in,
	input  wire logic             avs_read_in,
	input  wire logic             avs_write_in,
	input  wire logic [31:0]      avs_writedata_in,
	input  wire logic [3:0]       avs_byteenable_in,
	output logic      [31:0]      avs_readdata_out,
	output logic                  avs_waitrequest_out,
	output logic                  irq_out,
	input  wire logic             dout_start_in,
	input  wire logic [31:0]      dout_total_in,
	input  wire logic [31:0]      dout_offset_in,
	input  wire logic [31:0]      dout_length_in,
	input  wire logic [15:0]      dout_tag_in,
	input  wire logic             wdata_frame_in,
	input  wire logic [31:0]      wdata_bytes_in,
	input  wire logic             ack_sent_in,
	input  wire logic             cancel_in,
	output logic                  rx_done_out,
	output logic      [2:0]       rx_done_code_out,
	output logic      [15:0]      cmd_tag_out,
	output logic                  xfer_rdy_req_out,
	output logic      [31:0]      xfer_rdy_offset_out,
	output logic      [31:0]      xfer_rdy_length_out,
	output logic                  resp_ready_out,
	input  wire logic             app_resp_in,
	input  wire logic [7:0]       app_status_in,
	input  wire logic [SLW-1:0]   app_sense_len_in,
	input  wire logic             tport_resp_in,
	input  wire logic [2:0]       tport_code_in,
	input  wire logic [15:0]      resp_tag_in,
	input  wire logic [23:0]      resp_dest_hash_in,
	input  wire logic [7:0]       sense_data_in,
	input  wire logic             sense_valid_in,
	output logic                  sense_ready_out,
	output logic      [7:0]       tx_data_out,
	output logic                  tx_valid_out,
	output logic                  tx_last_out,
	input  wire logic             tx_ready_in,
	output logic                  tx_cancel_out
);

	////////////////////////////////////////////////////////////////////////////
	// types and state

	typedef enum logic [1:0] {
		STRB_IDLE = 2'b00,
		STRB_RX   = 2'b01,
		STRB_RESP = 2'b10
	} strb_state_e;

	typedef struct packed {
		strb_state_e                  st;
		logic [31:0]                  rcvd;
		logic [31:0]                  total;
		logic [31:0]                  roff;
		logic [31:0]                  rlen;
		logic [15:0]                  tag;
		logic [15:0]                  pend;
		logic                         rx_done;
		logic [2:0]                   rx_code;
		logic                         xrdy;
		logic                         is_tport;
		logic [7:0]                   status;
		logic [SLW-1:0]               slen;
		logic [7:0]                   code;
		logic [23:0]                  dest;
		logic [15:0]                  idx;
		logic [7:0]                   tx_data;
		logic                         tx_valid;
		logic                         tx_last;
		logic                         tx_cancel;
		logic [23:0]                  own_hash;
		logic [strb_pkg::IRQ_BITS-1:0] irq_st;
		logic [strb_pkg::IRQ_BITS-1:0] irq_mask;
		logic                         ack;
		logic [31:0]                  rdata;
	} strb_regs_s;

	strb_regs_s q;
	strb_regs_s next_q;

	////////////////////////////////////////////////////////////////////////////
	// helper functions

	// byte k (0 = most significant) of a big endian word
	function automatic logic [7:0] be_byte(input logic [31:0] w, input logic [15:0] k);
		logic [7:0] b;
		b = 8'h00;
		case (k[1:0])
			2'h0: b = w[31:24];
			2'h1: b = w[23:16];
			2'h2: b = w[15:8];
			default: b = w[7:0];
		endcase
		return b;
	endfunction

	// merge a write into a register under byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
						 input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// transport argument to response data code
	function automatic logic [7:0] resp_code(input logic [2:0] a);
		logic [7:0] c;
		c = strb_pkg::RC_INVALID_FRAME;
		case (strb_pkg::strb_targ_e'(a))
			strb_pkg::STRB_TA_COMPLETE:      c = strb_pkg::RC_COMPLETE;
			strb_pkg::STRB_TA_SUCCEEDED:     c = strb_pkg::RC_SUCCEEDED;
			strb_pkg::STRB_TA_NOT_SUPPORTED: c = strb_pkg::RC_NOT_SUPPORTED;
			strb_pkg::STRB_TA_FAILED:        c = strb_pkg::RC_FAILED;
			strb_pkg::STRB_TA_BAD_LUN:       c = strb_pkg::RC_BAD_LUN;
			strb_pkg::STRB_TA_OVERLAP_TAG:   c = strb_pkg::RC_OVERLAP_TAG;
			default:                         c = strb_pkg::RC_INVALID_FRAME;
		endcase
		return c;
	endfunction

	// header and fixed information unit byte at frame position i
	function automatic logic [7:0] fixed_byte(input logic [15:0] i, input strb_regs_s s,
						  input logic [1:0] fill, input logic [31:0] slen32);
		logic [7:0] b;
		logic [1:0] dp;
		b = 8'h00;
		dp = s.is_tport ? strb_pkg::DATAPRES_RESP :
		     ((s.slen != '0) ? strb_pkg::DATAPRES_SENSE : strb_pkg::DATAPRES_NONE); // RULE_07 RULE_10
		if (i == strb_pkg::HB_FRAME_TYPE) begin
			b = strb_pkg::FRAME_TYPE_RESPONSE; // RULE_04
		end else if (i >= strb_pkg::HB_DEST && i < strb_pkg::HB_DEST + 16'h0003) begin
			b = be_byte({8'h00, s.dest}, i - strb_pkg::HB_DEST + 16'h0001); // RULE_06
		end else if (i >= strb_pkg::HB_SRC && i < strb_pkg::HB_SRC + 16'h0003) begin
			b = be_byte({8'h00, s.own_hash}, i - strb_pkg::HB_SRC + 16'h0001); // RULE_06
		end else if (i == strb_pkg::HB_FLAGS) begin
			b = 8'h00; // RULE_05
		end else if (i == strb_pkg::HB_FILL) begin
			b = {6'h00, fill}; // RULE_09 RULE_11
		end else if (i == strb_pkg::HB_TAG) begin
			b = s.tag[15:8]; // RULE_06
		end else if (i == strb_pkg::HB_TAG + 16'h0001) begin
			b = s.tag[7:0];
		end else if (i == strb_pkg::IU_BASE + strb_pkg::IU_DATAPRES) begin
			b = {6'h00, dp};
		end else if (i == strb_pkg::IU_BASE + strb_pkg::IU_STATUS) begin
			b = s.is_tport ? 8'h00 : s.status; // RULE_07 RULE_10
		end else if (i >= strb_pkg::IU_BASE + strb_pkg::IU_SENSE_LEN &&
			     i < strb_pkg::IU_BASE + strb_pkg::IU_RESP_LEN) begin
			b = be_byte(slen32, i); // RULE_07 RULE_10
		end else if (i >= strb_pkg::IU_BASE + strb_pkg::IU_RESP_LEN &&
			     i < strb_pkg::PAYLOAD_START) begin
			b = be_byte(s.is_tport ? strb_pkg::TPORT_RESP_LEN : 32'h00000000, i); // RULE_07 RULE_11
		end else begin
			b = 8'h00; // transfer tag, data offset and reserved bytes RULE_05
		end
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// combinational next state

	logic [15:0] plen;
	logic [1:0]  fill;
	logic [15:0] flen;
	logic        slot_free;
	logic        in_pay;
	logic        bus_req;

	always_comb begin
		next_q = q;
		next_q.rx_done = 1'b0;
		next_q.xrdy = 1'b0;
		next_q.tx_cancel = 1'b0;
		plen = q.is_tport ? strb_pkg::TPORT_RESP_LEN[15:0] : 16'(q.slen);
		fill = 2'(16'h0000 - plen); // RULE_15
		flen = strb_pkg::PAYLOAD_START + plen + 16'(fill);
		slot_free = ~q.tx_valid | tx_ready_in;
		in_pay = (q.idx >= strb_pkg::PAYLOAD_START) && (q.idx < strb_pkg::PAYLOAD_START + plen);
		sense_ready_out = (q.st == STRB_RESP) && ~q.is_tport && in_pay && slot_free;
		resp_ready_out = (q.st == STRB_IDLE) && ~q.tx_valid && ~dout_start_in;
		if (q.tx_valid && tx_ready_in) begin
			next_q.tx_valid = 1'b0;
			next_q.tx_last = 1'b0;
		end
		// hardware events, set wins over a software clear
		bus_req = (avs_read_in | avs_write_in) & ~q.ack;
		next_q.ack = bus_req;
		if (q.ack && avs_write_in) begin
			case (avs_address_in)
				strb_pkg::REG_OWN_HASH: begin
					next_q.own_hash = 24'(be_merge({8'h00, q.own_hash}, avs_writedata_in,
							avs_byteenable_in));
				end
				strb_pkg::REG_IRQ_STATUS: begin
					if (avs_byteenable_in[0]) begin
						next_q.irq_st = q.irq_st & ~avs_writedata_in[strb_pkg::IRQ_BITS-1:0];
					end
				end
				strb_pkg::REG_IRQ_MASK: begin
					if (avs_byteenable_in[0]) begin
						next_q.irq_mask = avs_writedata_in[strb_pkg::IRQ_BITS-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		// read data stands while waitrequest is low
		if (bus_req) begin
			case (avs_address_in)
				strb_pkg::REG_OWN_HASH:   next_q.rdata = {8'h00, q.own_hash};
				strb_pkg::REG_STATE:      next_q.rdata = {q.pend, 14'h0000, q.st};
				strb_pkg::REG_RCVD:       next_q.rdata = q.rcvd;
				strb_pkg::REG_IRQ_STATUS: next_q.rdata = {28'h0000000, q.irq_st};
				strb_pkg::REG_IRQ_MASK:   next_q.rdata = {28'h0000000, q.irq_mask};
				default:                  next_q.rdata = 32'h00000000;
			endcase
		end
		case (q.st)
			STRB_IDLE: begin
				if (dout_start_in) begin
					next_q.st = STRB_RX;
					next_q.total = dout_total_in;
					next_q.roff = dout_offset_in;
					next_q.rlen = dout_length_in;
					next_q.rcvd = dout_offset_in;
					next_q.tag = dout_tag_in;
					next_q.pend = 16'h0000;
				end else if (resp_ready_out && (app_resp_in || tport_resp_in)) begin
					next_q.st = STRB_RESP;
					next_q.is_tport = tport_resp_in;
					next_q.status = app_status_in;
					next_q.slen = tport_resp_in ? '0 : app_sense_len_in; // RULE_07 RULE_10
					next_q.code = resp_code(tport_code_in); // RULE_08
					next_q.dest = resp_dest_hash_in; // RULE_06
					next_q.tag = resp_tag_in; // RULE_06
					next_q.idx = 16'h0000;
				end
			end
			STRB_RX: begin
				next_q.pend = q.pend + 16'(wdata_frame_in) - 16'(ack_sent_in);
				if (cancel_in) begin
					next_q.rx_done = 1'b1; // RULE_14
					next_q.rx_code = strb_pkg::RX_TERMINATED; // RULE_14
					next_q.st = STRB_IDLE; // RULE_01
				end else if (wdata_frame_in && (q.rcvd + wdata_bytes_in > q.total)) begin
					next_q.rx_done = 1'b1;
					next_q.rx_code = strb_pkg::RX_TOO_MUCH;
					next_q.st = STRB_IDLE; // RULE_01
				end else if (wdata_frame_in && (wdata_bytes_in == 32'h00000000)) begin
					next_q.rx_done = 1'b1;
					next_q.rx_code = strb_pkg::RX_IU_TOO_SHORT;
					next_q.st = STRB_IDLE; // RULE_01
				end else if (wdata_frame_in) begin
					next_q.rcvd = q.rcvd + wdata_bytes_in; // RULE_13
				end else if (q.pend == 16'h0000 && !ack_sent_in) begin
					if (q.rcvd == q.total) begin
						next_q.rx_done = 1'b1;
						next_q.rx_code = strb_pkg::RX_DATA_RECEIVED;
						next_q.st = STRB_IDLE; // RULE_01
					end else if (q.rcvd < q.total && q.rcvd == q.roff + q.rlen) begin // RULE_02
						next_q.rlen = q.total - q.roff; // RULE_03
						next_q.roff = q.rcvd; // RULE_03
						next_q.xrdy = 1'b1;
					end
				end
			end
			STRB_RESP: begin
				if (cancel_in) begin
					next_q.tx_cancel = 1'b1; // RULE_12
					next_q.tx_valid = 1'b0;
					next_q.tx_last = 1'b0;
					next_q.st = STRB_IDLE;
				end else if (slot_free && (!sense_ready_out || sense_valid_in)) begin
					if (q.idx < strb_pkg::PAYLOAD_START) begin
						next_q.tx_data = fixed_byte(q.idx, q, fill, 32'(q.slen));
					end else if (in_pay && q.is_tport) begin
						next_q.tx_data = (q.idx == strb_pkg::PAYLOAD_START + strb_pkg::RESP_CODE_POS) ?
								q.code : 8'h00; // RULE_08
					end else if (in_pay) begin
						next_q.tx_data = sense_data_in; // RULE_11
					end else begin
						next_q.tx_data = 8'h00; // RULE_15
					end
					next_q.tx_valid = 1'b1;
					next_q.tx_last = (q.idx == flen - 16'h0001);
					next_q.idx = q.idx + 16'h0001;
					if (q.idx == flen - 16'h0001) begin
						next_q.st = STRB_IDLE; // RULE_12
					end
				end
			end
			default: begin
				next_q.st = STRB_IDLE;
			end
		endcase
		// sticky interrupt status
		if (next_q.rx_done) begin
			next_q.irq_st[strb_pkg::IRQ_RX_DONE] = 1'b1;
		end
		if (next_q.xrdy) begin
			next_q.irq_st[strb_pkg::IRQ_XFER_RDY] = 1'b1;
		end
		if (next_q.tx_last && next_q.tx_valid && !q.tx_last) begin
			next_q.irq_st[strb_pkg::IRQ_FRAME_SENT] = 1'b1;
		end
		if (cancel_in && q.st != STRB_IDLE) begin
			next_q.irq_st[strb_pkg::IRQ_CANCEL] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	// synchronous reset to all zero, idle state has code zero
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			q <= '0;
			q.own_hash <= strb_pkg::OWN_HASH_RESET;
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	// one wait cycle per access keeps read data registered
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~q.ack;
	assign avs_readdata_out    = q.rdata;
	assign irq_out             = |(q.irq_st & q.irq_mask);
	assign rx_done_out         = q.rx_done;
	assign rx_done_code_out    = q.rx_code;
	assign cmd_tag_out         = q.tag;
	assign xfer_rdy_req_out    = q.xrdy;
	assign xfer_rdy_offset_out = q.roff;
	assign xfer_rdy_length_out = q.rlen;
	assign tx_data_out         = q.tx_data;
	assign tx_valid_out        = q.tx_valid;
	assign tx_last_out         = q.tx_last;
	assign tx_cancel_out       = q.tx_cancel;

endmodule

// [bench/strb_checker.sv]
// port assertions for the response builder, bound to strb_top
`timescale 1ns/1ps
module strb_checker (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic        wdata_frame_in,
	input  wire logic [31:0] wdata_bytes_in,
	input  wire logic        ack_sent_in,
	input  wire logic        cancel_in,
	input  wire logic        dout_start_in,
	input  wire logic [31:0] dout_total_in,
	input  wire logic        rx_done_out,
	input  wire logic [2:0]  rx_done_code_out,
	input  wire logic        xfer_rdy_req_out,
	input  wire logic [31:0] xfer_rdy_offset_out,
	input  wire logic        resp_ready_out,
	input  wire logic [7:0]  tx_data_out,
	input  wire logic        tx_valid_out,
	input  wire logic        tx_last_out,
	input  wire logic        tx_ready_in,
	input  wire logic        tx_cancel_out
);
	logic [7:0] idx;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	//////////////////////////////////////////////////////////////////////////////
	// byte position inside the frame, restarted by the last byte or a cancel
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || tx_cancel_out)
			idx <= 8'h00;
		else if (tx_valid_out && tx_ready_in)
			idx <= tx_last_out ? 8'h00 : idx + 8'h01;
	end
	//////////////////////////////////////////////////////////////////////////////
	// reception decisions
	a_done_idle: assert property (rx_done_out && !dout_start_in |-> resp_ready_out)
		else $error("not idle after reception complete");
	a_all_received: assert property (rx_done_out && rx_done_code_out == strb_pkg::RX_DATA_RECEIVED
		|-> $past(!wdata_frame_in && !ack_sent_in)) else $error("completion with acks outstanding");
	a_window_below: assert property (xfer_rdy_req_out |-> xfer_rdy_offset_out < dout_total_in)
		else $error("window request at or past total");
	a_window_quiet: assert property (xfer_rdy_req_out |-> $past(!wdata_frame_in && !ack_sent_in))
		else $error("window request while frames in flight");
	a_cancel_term: assert property (rx_done_out && rx_done_code_out == strb_pkg::RX_TERMINATED
		|-> $past(cancel_in)) else $error("terminated without cancel");
	a_empty_frame: assert property (rx_done_out && rx_done_code_out == strb_pkg::RX_IU_TOO_SHORT
		|-> $past(wdata_frame_in) && $past(wdata_bytes_in) == 32'h0) else $error("short unit misflagged");
	// frame stream
	a_type_code: assert property (tx_valid_out && idx == 8'h00 |-> tx_data_out == 8'h07)
		else $error("first byte not response type");
	a_zero_header: assert property (tx_valid_out && idx inside {8'h04, [8'h08:8'h0A], [8'h0C:8'h0F], [8'h12:8'h17]}
		|-> tx_data_out == 8'h00) else $error("reserved header byte not zero");
	a_fill_align: assert property (tx_valid_out && tx_last_out |-> idx[1:0] == 2'h3)
		else $error("frame not on four byte boundary");
	a_stall_hold: assert property (tx_valid_out && !tx_ready_in && !cancel_in
		|=> tx_valid_out && $stable(tx_data_out)) else $error("byte lost under stall");
	a_cancel_drop: assert property (tx_cancel_out |-> !tx_valid_out) else $error("bytes after cancel");
	c_window: cover property (xfer_rdy_req_out);
	c_term: cover property (rx_done_out && rx_done_code_out == strb_pkg::RX_TERMINATED);
	c_last: cover property (tx_valid_out && tx_last_out && tx_ready_in);
	c_cancel: cover property (tx_cancel_out);
endmodule
bind strb_top strb_checker u_chk (.*);

// [bench/strb_sink.sv]
// far side model: initiator port taking the response frame byte stream
`timescale 1ns/1ps
module strb_sink (
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	input  wire logic       slow_in,
	input  wire logic [7:0] tx_data_in,
	input  wire logic       tx_valid_in,
	input  wire logic       tx_last_in,
	output logic            tx_ready_out
);
	logic [7:0] got[$];
	int         frames = 0;
	logic       phase = 1'b0;
	initial tx_ready_out = 1'b0;
	// slow mode gives ready every other cycle so the builder has to hold bytes
	always @(posedge ref_clk_in) begin
		phase <= rst_in ? 1'b0 : !phase;
		tx_ready_out <= !rst_in && (!slow_in || !phase);
		if (tx_valid_in === 1'b1 && tx_ready_out) begin
			got.push_back(tx_data_in);
			if (tx_last_in === 1'b1)
				frames <= frames + 1;
		end
	end
endmodule

// [bench/strb_tb_top.sv]
// self-checking bench for the ssp target response builder
`timescale 1ns/1ps
module strb_tb_top;
	logic        ref_clk_in = 1'b0, rst_in = 1'b1, slow = 1'b0;
	logic [5:0]  avs_address_in = 6'h00;
	logic        avs_read_in = 1'b0, avs_write_in = 1'b0, avs_waitrequest_out, irq_out;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
	logic [3:0]  avs_byteenable_in = 4'hF;
	logic        dout_start_in = 1'b0, wdata_frame_in = 1'b0, ack_sent_in = 1'b0, cancel_in = 1'b0;
	logic [31:0] dout_total_in = 32'h0, dout_offset_in = 32'h0, dout_length_in = 32'h0, wdata_bytes_in = 32'h0;
	logic [15:0] dout_tag_in = 16'h0, resp_tag_in = 16'h5A6B, cmd_tag_out, dtag;
	logic        rx_done_out, xfer_rdy_req_out, resp_ready_out, sense_ready_out;
	logic [2:0]  rx_done_code_out, dcode, tport_code_in = 3'h0;
	logic [31:0] xfer_rdy_offset_out, xfer_rdy_length_out, xo, xl;
	logic        app_resp_in = 1'b0, tport_resp_in = 1'b0, sense_valid_in = 1'b1;
	logic [7:0]  app_status_in = 8'h0, app_sense_len_in = 8'h0, sense_data_in = 8'hA0, tx_data_out;
	logic [23:0] resp_dest_hash_in = 24'hC1D2E3;
	logic        tx_valid_out, tx_last_out, tx_ready_in, tx_cancel_out;
	logic [7:0]  e[0:63];
	logic [7:0]  rcs[0:6] = '{8'h02, 8'h00, 8'h08, 8'h04, 8'h05, 8'h09, 8'h0A};
	int          num_errors = 0, checks = 0, dn = 0, xn = 0, cn = 0, d0, k;
	// every port meets a bench signal of the same name
	strb_top #(.SLW(8)) u_dut (.*);
	strb_sink u_sink (.ref_clk_in, .rst_in, .slow_in(slow), .tx_data_in(tx_data_out), .tx_valid_in(tx_valid_out),
		.tx_last_in(tx_last_out), .tx_ready_out(tx_ready_in));
	//////////////////////////////////////////////////////////////////////////////
	// clock, event capture and the sense byte source
	always #25 ref_clk_in = !ref_clk_in;
	always @(posedge ref_clk_in) begin
		if (rx_done_out === 1'b1) begin
			dn <= dn + 1;
			dcode <= rx_done_code_out;
			dtag <= cmd_tag_out;
		end
		if (xfer_rdy_req_out === 1'b1) begin
			xn <= xn + 1;
			xo <= xfer_rdy_offset_out;
			xl <= xfer_rdy_length_out;
		end
		if (tx_cancel_out === 1'b1)
			cn <= cn + 1;
		if (sense_ready_out === 1'b1)
			sense_data_in <= sense_data_in + 8'h01;
	end
	//////////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one avalon transfer; the request stays up until waitrequest is seen low
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		k = 0;
		do begin
			@(posedge ref_clk_in);
			k++;
		end while (avs_waitrequest_out !== 1'b0 && k < 50);
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask
	// one-cycle pulse: 0 data frame, 1 ack, 2 cancel, 3 start
	task strobe(input int w, input logic [31:0] b);
		@(posedge ref_clk_in);
		wdata_bytes_in <= b;
		case (w)
			0: wdata_frame_in <= 1'b1;
			1: ack_sent_in <= 1'b1;
			2: cancel_in <= 1'b1;
			default: dout_start_in <= 1'b1;
		endcase
		@(posedge ref_clk_in);
		{wdata_frame_in, ack_sent_in, cancel_in, dout_start_in} <= 4'h0;
	endtask
	task rx_start(input logic [31:0] t, input logic [31:0] l, input logic [15:0] g);
		dout_total_in <= t;
		dout_offset_in <= 32'h0;
		dout_length_in <= l;
		dout_tag_in <= g;
		d0 = dn;
		strobe(3, 32'h0);
	endtask
	task rx_end(input logic [2:0] code, input logic [15:0] g);
		for (k = 0; k < 100 && dn == d0; k++) @(posedge ref_clk_in);
		chk("completion code", dcode, code);
		chk("completion tag", dtag, g);
	endtask
	// send one response and compare the whole frame, or cancel it a few bytes in
	task resp(input logic tp, input int c, input logic [7:0] st, input int sl, input logic sm, input logic cut);
		int i, pl, f0, c0;
		pl = tp ? 4 : sl;
		for (i = 0; i < 64; i++) e[i] = 8'h00;
		{e[0], e[1], e[2], e[3]} = {8'h07, resp_dest_hash_in};
		{e[5], e[6], e[7]} = 24'h3C4D5E;
		e[11] = 8'((4 - pl % 4) % 4);
		{e[16], e[17]} = resp_tag_in;
		e[34] = tp ? 8'h01 : (sl != 0 ? 8'h02 : 8'h00);
		e[35] = tp ? 8'h00 : st;
		e[43] = tp ? 8'h00 : 8'(sl);
		e[47] = tp ? 8'h04 : 8'h00;
		if (tp) e[51] = rcs[c];
		else for (i = 0; i < sl; i++) e[48 + i] = 8'hA0 + 8'(i);
		for (i = 0; i < 100 && resp_ready_out !== 1'b1; i++) @(posedge ref_clk_in);
		u_sink.got.delete();
		f0 = u_sink.frames;
		c0 = cn;
		@(posedge ref_clk_in);
		slow <= sm;
		sense_data_in <= 8'hA0;
		{app_status_in, app_sense_len_in, tport_code_in} <= {st, 8'(sl), 3'(c)};
		{tport_resp_in, app_resp_in} <= {tp, !tp};
		@(posedge ref_clk_in);
		{tport_resp_in, app_resp_in} <= 2'b00;
		if (cut) begin
			repeat (6) @(posedge ref_clk_in);
			strobe(2, 32'h0);
			repeat (4) @(posedge ref_clk_in);
			chk("cancel pulses", cn, c0 + 1);
			chk("frames after cancel", u_sink.frames, f0);
		end else begin
			for (i = 0; i < 400 && u_sink.frames == f0; i++) @(posedge ref_clk_in);
			chk("frame length", u_sink.got.size(), 48 + pl + (4 - pl % 4) % 4);
			for (i = 0; i < u_sink.got.size() && i < 64; i++)
				chk("frame byte", u_sink.got[i], e[i]);
		end
	endtask
	task conclude;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		bus(1'b1, strb_pkg::REG_OWN_HASH, 32'h003C4D5E);
		bus(1'b0, strb_pkg::REG_OWN_HASH, 32'h0);
		chk("own address", rd, 32'h003C4D5E);
		bus(1'b0, 6'h3C, 32'h0);
		chk("unmapped read", rd, 32'h0);
		bus(1'b1, strb_pkg::REG_IRQ_MASK, 32'h00000001);
		// window walk: the next window waits for every ack
		rx_start(32'd8, 32'd4, 16'h1234);
		strobe(0, 32'd4);
		repeat (3) @(posedge ref_clk_in);
		chk("early window", xn, 0);
		strobe(1, 32'h0);
		for (k = 0; k < 50 && xn == 0; k++) @(posedge ref_clk_in);
		chk("window offset", xo, 32'd4);
		chk("window length", xl, 32'd8);
		strobe(0, 32'd4);
		strobe(1, 32'h0);
		rx_end(strb_pkg::RX_DATA_RECEIVED, 16'h1234);
		@(posedge ref_clk_in);
		chk("irq raised", {31'h0, irq_out}, 32'h1);
		bus(1'b1, strb_pkg::REG_IRQ_STATUS, 32'h00000001);
		@(posedge ref_clk_in);
		chk("irq cleared", {31'h0, irq_out}, 32'h0);
		// cancel, too much data, empty frame
		for (int j = 0; j < 3; j++) begin
			rx_start(32'd16, 32'd16, 16'h2000 + 16'(j));
			strobe(j == 0 ? 2 : 0, j == 1 ? 32'd20 : 32'd0);
			rx_end(3'(j + 1), 16'h2000 + 16'(j));
		end
		// every transport code, application responses, then transport code 6 again
		for (int j = 0; j < 7; j++) resp(1'b1, j, 8'h00, 0, j[0], 1'b0);
		resp(1'b0, 0, 8'h02, 5, 1'b1, 1'b0);
		resp(1'b0, 0, 8'h00, 0, 1'b0, 1'b0);
		resp(1'b0, 0, 8'h02, 5, 1'b1, 1'b1);
		resp(1'b1, 6, 8'h00, 0, 1'b0, 1'b0);
		conclude();
	end
	// watchdog: the whole sequence needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		num_errors++;
		conclude();
	end
endmodule
